// ===== cnf_cfg.svh
`ifndef CNF_CFG_SVH
`define CNF_CFG_SVH

// ==========================================================
// register byte offsets
`define CNF_OFS_FRONT_CONFIG   8'h00
`define CNF_OFS_CENTER_FREQ    8'h04
`define CNF_OFS_PHASE_OFFSET   8'h08
`define CNF_OFS_CF_COMMIT      8'h0c
`define CNF_OFS_PH_COMMIT      8'h10
`define CNF_OFS_SYNC_CONTROL   8'h14
`define CNF_OFS_PHASE_STATUS   8'h18
`define CNF_OFS_OFFSET_STATUS  8'h1c

// ==========================================================
// front config fields
`define CNF_BIT_ACC_CLEAR      0
`define CNF_BIT_OFFSET_ZERO    1
`define CNF_FLD_CWIDTH_LO      4
`define CNF_FLD_CWIDTH_HI      5
`define CNF_BIT_CIC_BYPASS     6
`define CNF_FLD_DECIM_LO       7
`define CNF_FLD_DECIM_HI       12
`define CNF_FLD_SGAIN_LO       13
`define CNF_FLD_SGAIN_HI       16

// ==========================================================
// sync control fields
`define CNF_FLD_RWIDTH_LO      3
`define CNF_FLD_RWIDTH_HI      4
`define CNF_BIT_SYNC_UPDATE    20

// ==========================================================
// reset values and limits
`define CNF_RST_WORD           32'h0000_0000
`define CNF_RST_PHASE          10'h000
`define CNF_SHIFT_MAX          5'h0f
`define CNF_AMP_MAX            17'h1ffff
`define CNF_HALF_CYCLE         18'h20000
`define CNF_QUARTER_CYCLE      18'h10000
`define CNF_MIX_MAX            15'h3fff
`define CNF_MIX_MIN            15'h4000

`endif

// ===== cnf_pkg.sv
package cnf_pkg;
   typedef enum logic [1:0] {
      LD_IDLE,
      LD_SHIFT
   } cnf_ld_state_t;
   typedef logic signed [17:0] cnf_amp_t;
   typedef logic signed [14:0] cnf_mix_t;
endpackage

// ===== cnf_front.sv
`timescale 1ns/1ps
`default_nettype none
`include "cnf_cfg.svh"

module cnf_front (
   // clock, reset, enable
   input  wire  logic        I_CLK_SYS,
   input  wire  logic        I_RST,
   input  wire  logic        I_CE,
   // apb slave
   input  wire  logic        I_PSEL,
   input  wire  logic        I_PENABLE,
   input  wire  logic        I_PWRITE,
   input  wire  logic [7:0]  I_PADDR,
   input  wire  logic [31:0] I_PWDATA,
   output logic              O_PREADY,
   output logic              O_PSLVERR,
   output logic       [31:0] O_PRDATA,
   // sample input
   input  wire  logic        I_SAMPLE_ENABLE_LOW,
   input  wire  logic [13:0] I_SAMPLE,
   input  wire  logic [2:0]  I_GAIN_OFFSET_PINS,
   input  wire  logic        I_FRONT_SYNC_INPUT,
   // serial offset loaders
   input  wire  logic        I_CARRIER_OFFSET_SERIAL_DATA,
   input  wire  logic        I_CARRIER_OFFSET_WORD_MARK,
   input  wire  logic        I_RESAMPLER_OFFSET_SERIAL_DATA,
   input  wire  logic        I_RESAMPLER_OFFSET_WORD_MARK,
   output logic       [31:0] O_RESAMPLER_OFFSET,
   // shifted mixer output toward cic
   output logic              O_MIX_VALID,
   output logic       [29:0] O_I_SHIFTED,
   output logic       [29:0] O_Q_SHIFTED,
   output logic       [3:0]  O_SHIFT_AMOUNT,
   output logic       [5:0]  O_CIC_DECIM_M1,
   output logic              O_CIC_BYPASS
);

   // ==========================================================
   // functions
   function automatic logic [5:0] width_bits(input logic [1:0] code);
      // widen first: code 3 must give 32, not wrap to zero
      width_bits = {3'(code) + 3'd1, 3'b000};
   endfunction

   // parabolic half-wave shape: cheap stand-in for a full 2^18 rom
   function automatic cnf_pkg::cnf_amp_t sine_of(input logic [17:0] ph);
      logic [16:0] x;
      logic [34:0] y;
      logic [16:0] m;
      x = ph[16:0];
      y = 35'({18'h0, x} * (`CNF_HALF_CYCLE - {1'b0, x}));
      m = y[32] ? `CNF_AMP_MAX : y[31:15];
      sine_of = ph[17] ? -cnf_pkg::cnf_amp_t'({1'b0, m}) : cnf_pkg::cnf_amp_t'({1'b0, m});
   endfunction

   // round half away from zero, saturate to 15 bits
   function automatic cnf_pkg::cnf_mix_t round15(input logic signed [31:0] p);
      logic signed [32:0] s;
      s = {p[31], p} + (p[31] ? 33'sh0_7fff : 33'sh0_8000);
      if (!s[32] && s[31:30] != 2'b00)
         round15 = `CNF_MIX_MAX;
      else if (s[32] && s[31:30] != 2'b11)
         round15 = `CNF_MIX_MIN;
      else
         round15 = s[30:16];
   endfunction

   // ==========================================================
   // apb register file
   logic [31:0] cfg_q;
   logic [31:0] cf_hold_q;
   logic [31:0] cf_act_q;
   logic [9:0]  ph_hold_q;
   logic [9:0]  ph_act_q;
   logic [31:0] sync_ctl_q;
   logic [31:0] prdata_q;
   logic [31:0] acc_q;
   logic [31:0] hold_q [2];

   wire         setup    = I_PSEL && !I_PENABLE;
   wire         wr_acc   = I_PSEL && I_PENABLE && I_PWRITE && I_CE;
   wire         hit_cfg  = I_PADDR == `CNF_OFS_FRONT_CONFIG;
   wire         hit_cf   = I_PADDR == `CNF_OFS_CENTER_FREQ;
   wire         hit_ph   = I_PADDR == `CNF_OFS_PHASE_OFFSET;
   wire         hit_cfc  = I_PADDR == `CNF_OFS_CF_COMMIT;
   wire         hit_phc  = I_PADDR == `CNF_OFS_PH_COMMIT;
   wire         hit_syn  = I_PADDR == `CNF_OFS_SYNC_CONTROL;
   wire         hit_phs  = I_PADDR == `CNF_OFS_PHASE_STATUS;
   wire         hit_ofs  = I_PADDR == `CNF_OFS_OFFSET_STATUS;
   wire         mapped   = hit_cfg | hit_cf | hit_ph | hit_cfc | hit_phc | hit_syn
                           | hit_phs | hit_ofs;
   // write-only words read as zero; only the two status words return state
   wire  [31:0] rd_mux   = hit_phs ? acc_q : hit_ofs ? hold_q[0] : 32'h0000_0000;

   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
   assign O_PRDATA  = prdata_q;

   wire         sync_xfer = I_FRONT_SYNC_INPUT && sync_ctl_q[`CNF_BIT_SYNC_UPDATE];
   wire         cf_xfer   = sync_xfer || (wr_acc && hit_cfc);
   wire         ph_xfer   = sync_xfer || (wr_acc && hit_phc);

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         cfg_q      <= `CNF_RST_WORD;
         cf_hold_q  <= `CNF_RST_WORD;
         ph_hold_q  <= `CNF_RST_PHASE;
         sync_ctl_q <= `CNF_RST_WORD;
         prdata_q   <= `CNF_RST_WORD;
      end else if (I_CE) begin
         if (setup && !I_PWRITE)
            prdata_q <= rd_mux;
         if (wr_acc && hit_cfg)
            cfg_q <= I_PWDATA;
         if (wr_acc && hit_cf)
            cf_hold_q <= I_PWDATA;
         if (wr_acc && hit_ph)
            ph_hold_q <= I_PWDATA[9:0];
         if (wr_acc && hit_syn)
            sync_ctl_q <= I_PWDATA;
      end
   end

   // ==========================================================
   // holding to active transfer
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         cf_act_q <= `CNF_RST_WORD;
         ph_act_q <= `CNF_RST_PHASE;
      end else if (I_CE) begin
         if (cf_xfer)
            cf_act_q <= cf_hold_q;
         if (ph_xfer)
            ph_act_q <= ph_hold_q;
      end
   end

   // ==========================================================
   // serial offset loaders: 0 = carrier, 1 = resampler
   // both run on the one system clock, so the resampler loader shares its edge
   wire  [1:0]  ser_data = {I_RESAMPLER_OFFSET_SERIAL_DATA, I_CARRIER_OFFSET_SERIAL_DATA};
   wire  [1:0]  ser_mark = {I_RESAMPLER_OFFSET_WORD_MARK, I_CARRIER_OFFSET_WORD_MARK};
   wire  [1:0]  wcode [2];
   assign wcode[0] = cfg_q[`CNF_FLD_CWIDTH_HI:`CNF_FLD_CWIDTH_LO];
   assign wcode[1] = sync_ctl_q[`CNF_FLD_RWIDTH_HI:`CNF_FLD_RWIDTH_LO];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_loader
         cnf_pkg::cnf_ld_state_t st_q;
         logic [5:0]  cnt_q;
         logic [31:0] sr_q;
         wire  [31:0] sr_d   = {sr_q[30:0], ser_data[g]};
         wire  [5:0]  pad    = 6'd32 - width_bits(wcode[g]);
         wire  [31:0] packed_w = sr_d << pad;
         wire         last   = st_q == cnf_pkg::LD_SHIFT && cnt_q == 6'd1;

         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               st_q      <= cnf_pkg::LD_IDLE;
               cnt_q     <= 6'h00;
               sr_q      <= `CNF_RST_WORD;
               hold_q[g] <= `CNF_RST_WORD;
            end else if (I_CE) begin
               case (st_q)
                  cnf_pkg::LD_IDLE: begin
                     if (ser_mark[g]) begin
                        st_q  <= cnf_pkg::LD_SHIFT;
                        cnt_q <= width_bits(wcode[g]);
                        sr_q  <= `CNF_RST_WORD;
                     end
                  end
                  cnf_pkg::LD_SHIFT: begin
                     sr_q  <= sr_d;
                     cnt_q <= cnt_q - 6'd1;
                     if (last) begin
                        hold_q[g] <= packed_w;
                        st_q      <= cnf_pkg::LD_IDLE;
                     end
                  end
                  default: st_q <= cnf_pkg::LD_IDLE;
               endcase
            end
         end

         property p_ld_width;
            @(posedge I_CLK_SYS) disable iff (I_RST)
               (I_CE && st_q == cnf_pkg::LD_IDLE && ser_mark[g])
                  |=> cnt_q == width_bits($past(wcode[g]));
         endproperty
         a_ld_width: assert property (p_ld_width) else $error("loader width count");
         property p_ld_low_zero;
            @(posedge I_CLK_SYS) disable iff (I_RST)
               (I_CE && last && wcode[g] == 2'b00) |=> hold_q[g][23:0] == 24'h00_0000;
         endproperty
         a_ld_low_zero: assert property (p_ld_low_zero) else $error("loader low bits");
      end
   endgenerate

   assign O_RESAMPLER_OFFSET = hold_q[1];

   // ==========================================================
   // carrier nco
   wire         offset_zero = cfg_q[`CNF_BIT_OFFSET_ZERO];
   wire  [31:0] freq_word   = cf_act_q + (offset_zero ? 32'h0000_0000 : hold_q[0]);
   wire         advance     = I_CE && !I_SAMPLE_ENABLE_LOW;
   wire         acc_clear   = cfg_q[`CNF_BIT_ACC_CLEAR] && (cf_xfer || ph_xfer);
   wire  [31:0] feedback    = acc_clear ? 32'h0000_0000 : acc_q;
   wire  [9:0]  phase_top   = acc_q[31:22] + ph_act_q;
   wire  [17:0] phase_addr  = {phase_top, acc_q[21:14]};

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST)
         acc_q <= `CNF_RST_WORD;
      else if (advance)
         acc_q <= feedback + freq_word;
      else if (I_CE && acc_clear)
         acc_q <= `CNF_RST_WORD;
   end

   // ==========================================================
   // mixer and shifter pipeline
   // three stages; gain pins follow the same stages so shift matches the sample
   cnf_pkg::cnf_amp_t sin_q;
   cnf_pkg::cnf_amp_t cos_q;
   logic signed [13:0] smp_q;
   cnf_pkg::cnf_mix_t  i_q;
   cnf_pkg::cnf_mix_t  q_q;
   logic [2:0]  gain_q [2];
   logic [2:0]  vld_q;
   logic [29:0] i_sh_q;
   logic [29:0] q_sh_q;
   logic [3:0]  amt_q;

   wire  [3:0]  sg       = cfg_q[`CNF_FLD_SGAIN_HI:`CNF_FLD_SGAIN_LO];
   wire  [4:0]  sum_gain = {1'b0, sg} + {2'b00, gain_q[1]};
   wire  [3:0]  amt      = sum_gain > `CNF_SHIFT_MAX ? 4'hf : sum_gain[3:0];
   wire  signed [31:0] prod_i = smp_q * cos_q;
   wire  signed [31:0] prod_q = smp_q * sin_q;

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         vld_q <= 3'b000;
         smp_q <= 14'h0000;
         sin_q <= 18'h00000;
         cos_q <= 18'h00000;
      end else if (I_CE) begin
         vld_q <= {vld_q[1:0], !I_SAMPLE_ENABLE_LOW};
         if (!I_SAMPLE_ENABLE_LOW) begin
            smp_q <= I_SAMPLE;
            sin_q <= sine_of(phase_addr);
            cos_q <= sine_of(phase_addr + `CNF_QUARTER_CYCLE);
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         i_q       <= 15'h0000;
         q_q       <= 15'h0000;
         gain_q[0] <= 3'h0;
         gain_q[1] <= 3'h0;
      end else if (I_CE) begin
         if (!I_SAMPLE_ENABLE_LOW)
            gain_q[0] <= I_GAIN_OFFSET_PINS;
         if (vld_q[0]) begin
            i_q       <= round15(prod_i);
            q_q       <= round15(prod_q);
            gain_q[1] <= gain_q[0];
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         i_sh_q <= 30'h0000_0000;
         q_sh_q <= 30'h0000_0000;
         amt_q  <= 4'h0;
      end else if (I_CE && vld_q[1]) begin
         i_sh_q <= {{15{i_q[14]}}, i_q} << amt;
         q_sh_q <= {{15{q_q[14]}}, q_q} << amt;
         amt_q  <= amt;
      end
   end

   // the cic takes decimation minus one as is; bypass needs gapped enables
   assign O_MIX_VALID    = vld_q[2];
   assign O_I_SHIFTED    = i_sh_q;
   assign O_Q_SHIFTED    = q_sh_q;
   assign O_SHIFT_AMOUNT = amt_q;
   assign O_CIC_DECIM_M1 = cfg_q[`CNF_FLD_DECIM_HI:`CNF_FLD_DECIM_LO];
   assign O_CIC_BYPASS   = cfg_q[`CNF_BIT_CIC_BYPASS];

   // ==========================================================
   // checks
   property p_acc_step;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (advance && !acc_clear) |=> acc_q == $past(acc_q) + $past(freq_word);
   endproperty
   a_acc_step: assert property (p_acc_step) else $error("accumulator step");

   property p_offset_zero;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         offset_zero |-> freq_word == cf_act_q;
   endproperty
   a_offset_zero: assert property (p_offset_zero) else $error("offset not zeroed");

   property p_hold_when_idle;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (I_SAMPLE_ENABLE_LOW && !acc_clear) |=> $stable(acc_q);
   endproperty
   a_hold_when_idle: assert property (p_hold_when_idle) else $error("accumulator moved");

   // a half-cycle offset on zero phase must flip the cosine to negative full scale
   property p_phase_add;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (I_CE && !I_SAMPLE_ENABLE_LOW && acc_q[31:14] == 18'h00000 && ph_act_q == 10'h200)
            |=> cos_q == 18'sh20001 && sin_q == 18'sh00000;
   endproperty
   a_phase_add: assert property (p_phase_add) else $error("phase offset not added");

   property p_commit_cf;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (wr_acc && hit_cfc) |=> cf_act_q == $past(cf_hold_q);
   endproperty
   a_commit_cf: assert property (p_commit_cf) else $error("frequency commit");

   property p_sync_both;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (I_CE && I_FRONT_SYNC_INPUT && sync_ctl_q[`CNF_BIT_SYNC_UPDATE])
            |=> cf_act_q == $past(cf_hold_q) && ph_act_q == $past(ph_hold_q);
   endproperty
   a_sync_both: assert property (p_sync_both) else $error("sync transfer");

   property p_clear;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (advance && acc_clear) |=> acc_q == $past(freq_word);
   endproperty
   a_clear: assert property (p_clear) else $error("accumulator clear");

   property p_shift_sat;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (I_CE && vld_q[1] && sum_gain > 5'd15) |=> amt_q == 4'hf;
   endproperty
   a_shift_sat: assert property (p_shift_sat) else $error("shift not saturated");

   property p_valid_lat;
      @(posedge I_CLK_SYS) disable iff (I_RST)
         (I_CE && !I_SAMPLE_ENABLE_LOW) ##1 I_CE[*2] |=> O_MIX_VALID;
   endproperty
   a_valid_lat: assert property (p_valid_lat) else $error("mixer valid latency");

endmodule

`default_nettype wire

// ===== cnf_serial_src.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// far-side source of serial offset words for one loader
module cnf_serial_src (
   // clock
   input  wire logic i_clk,
   // serial pins
   output logic      o_mark,
   output logic      o_data
);
   initial begin
      o_mark = 1'b0;
      o_data = 1'b0;
   end

   // call just after a rising edge; no pull on the data line, so after
   // the last bit it shows the inverse rather than a stale level
   task automatic send(input logic [31:0] w, input int n);
      o_mark <= 1'b1;
      @(posedge i_clk);
      o_mark <= 1'b0;
      for (int i = 31; i > 31 - n; i--) begin
         o_data <= w[i];
         @(posedge i_clk);
      end
      o_data <= ~w[32-n];
   endtask
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bench for the carrier front end
module testbench;
   logic        clk  = 1'b0;
   logic        rst  = 1'b1;
   logic        psel = 1'b0;
   logic        pen  = 1'b0;
   logic        pwr  = 1'b0;
   logic [7:0]  padr = 8'h00;
   logic [31:0] pwd  = 32'h0000_0000;
   logic        en_n = 1'b1;
   logic [13:0] smp  = 14'h0000;
   logic [2:0]  gpin = 3'h0;
   logic        sync = 1'b0;
   logic        prdy, perr, mvld, byp, cmk, cdat, rmk, rdat, er;
   logic [31:0] prd, roff, rd;
   logic [29:0] v_i, v_q;
   logic [3:0]  sh;
   logic [5:0]  dec;
   int          bad_count    = 0;
   int          total_checks = 0;
   int          cyc          = 0;

   cnf_front dut (
      .I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'b1),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
      .O_PREADY(prdy), .O_PSLVERR(perr), .O_PRDATA(prd),
      .I_SAMPLE_ENABLE_LOW(en_n), .I_SAMPLE(smp), .I_GAIN_OFFSET_PINS(gpin),
      .I_FRONT_SYNC_INPUT(sync),
      .I_CARRIER_OFFSET_SERIAL_DATA(cdat), .I_CARRIER_OFFSET_WORD_MARK(cmk),
      .I_RESAMPLER_OFFSET_SERIAL_DATA(rdat), .I_RESAMPLER_OFFSET_WORD_MARK(rmk),
      .O_RESAMPLER_OFFSET(roff), .O_MIX_VALID(mvld), .O_I_SHIFTED(v_i), .O_Q_SHIFTED(v_q),
      .O_SHIFT_AMOUNT(sh), .O_CIC_DECIM_M1(dec), .O_CIC_BYPASS(byp)
   );
   cnf_serial_src src_c (.i_clk(clk), .o_mark(cmk), .o_data(cdat));
   cnf_serial_src src_r (.i_clk(clk), .o_mark(rmk), .o_data(rdat));

   always #2.5 clk = ~clk;

   // ==========================================================
   // reporting
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // hang guard, generous against the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("ERROR %0t run did not finish", $time);
         close_out();
      end
   end

   // ==========================================================
   // expectations and drivers
   function automatic logic [31:0] exp_ser(input logic [31:0] w, input int c);
      logic [31:0] m;
      m = 32'hffff_ffff << (24 - 8 * c);
      return w & m;
   endfunction

   function automatic logic [3:0] exp_sh(input int sg, input int g);
      return (sg + g > 15) ? 4'hf : 4'(sg + g);
   endfunction

   // full-scale cosine sits just under 2^17, so the rounded product is twice the sample
   function automatic logic [29:0] exp_mix(input logic [13:0] s, input int p, input int a);
      logic signed [29:0] v;
      v = 30'(2 * $signed(s));
      if (p == 1)
         v = -v;
      return v << a;
   endfunction

   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= w;
      padr <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk);
   endtask

   task automatic run(input int k);
      for (int i = 0; i < k; i++) begin
         en_n <= 1'b0;
         smp  <= 14'($urandom);
         gpin <= 3'($urandom);
         @(posedge clk);
      end
      en_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] w, f, o, f2;
      logic [13:0] s;
      int          k, sg, g, dm;
      void'($urandom(32097));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(8'h40, 1'b0, 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001, "unmapped error");
      chk(rd, 32'h0000_0000, "unmapped read");
      $display("test apb done");
      // offset-zero set throughout: words must still land in holding
      for (int c = 0; c < 4; c++) begin
         w = $urandom;
         apb(8'h00, 1'b1, 32'h0000_0002 | (32'(c) << 4));
         apb(8'h14, 1'b1, 32'(c) << 3);
         fork
            src_c.send(w, 8 * (c + 1));
            src_r.send(~w, 8 * (c + 1));
         join
         apb(8'h1c, 1'b0, 32'h0000_0000);
         chk(rd, exp_ser(w, c), "carrier offset word");
         chk(roff, exp_ser(~w, c), "resampler offset word");
      end
      o = w;
      $display("test serial done");
      f = $urandom;
      k = $urandom_range(5, 40);
      apb(8'h00, 1'b1, 32'h0000_0033);
      apb(8'h04, 1'b1, f);
      apb(8'h0c, 1'b1, 32'h0000_0000);
      run(k);
      apb(8'h18, 1'b0, 32'h0000_0000);
      chk(rd, 32'(k) * f, "accumulator, offset zeroed");
      apb(8'h00, 1'b1, 32'h0000_0031);
      apb(8'h0c, 1'b1, 32'h0000_0000);
      run(k);
      apb(8'h18, 1'b0, 32'h0000_0000);
      chk(rd, 32'(k) * (f + o), "accumulator, with offset");
      f2 = $urandom;
      apb(8'h14, 1'b1, 32'h0010_0000);
      apb(8'h04, 1'b1, f2);
      sync <= 1'b1;
      @(posedge clk);
      sync <= 1'b0;
      run(k);
      apb(8'h18, 1'b0, 32'h0000_0000);
      chk(rd, 32'(k) * (f2 + o), "accumulator after sync");
      // clear and first sample on one edge; holding equals active, so the sum is unambiguous
      sync <= 1'b1;
      en_n <= 1'b0;
      @(posedge clk);
      sync <= 1'b0;
      run(k - 1);
      apb(8'h18, 1'b0, 32'h0000_0000);
      chk(rd, 32'(k) * (f2 + o), "accumulator, clear on a sample");
      $display("test nco done");
      apb(8'h04, 1'b1, 32'h0000_0000);
      apb(8'h0c, 1'b1, 32'h0000_0000);
      // first two cases are the shift corners, the rest random
      for (int t = 0; t < 6; t++) begin
         sg = (t == 0) ? 0 : (t == 1) ? 15 : $urandom_range(0, 15);
         g  = (t == 0) ? 0 : (t == 1) ? 7 : $urandom_range(0, 7);
         dm = (t == 1) ? 63 : $urandom_range(0, 63);
         apb(8'h00, 1'b1, 32'h0000_0003 | (32'(sg) << 13) | (32'(dm) << 7) | (32'(t & 1) << 6));
         chk({26'h0, dec}, 32'(dm), "decimation field");
         chk({31'h0, byp}, 32'(t & 1), "bypass field");
         for (int p = 0; p < 2; p++) begin
            s = 14'($urandom_range(64, 8000));
            if ($urandom_range(0, 1) == 1)
               s = -s;
            apb(8'h08, 1'b1, (p == 1) ? 32'h0000_0200 : 32'h0000_0000);
            apb(8'h10, 1'b1, 32'h0000_0000);
            en_n <= 1'b0;
            smp  <= s;
            gpin <= 3'(g);
            @(posedge clk);
            en_n <= 1'b1;
            gpin <= 3'($urandom);
            for (int j = 0; j < 10; j++) begin
               @(posedge clk);
               if (mvld === 1'b1)
                  break;
            end
            chk({31'h0, mvld}, 32'h0000_0001, "mixer output valid");
            chk({28'h0, sh}, {28'h0, exp_sh(sg, g)}, "shift amount");
            chk({2'h0, v_q}, 32'h0000_0000, "quadrature at zero sine");
            chk({2'h0, v_i}, {2'h0, exp_mix(s, p, exp_sh(sg, g))}, "in-phase value");
         end
      end
      $display("test mixer done");
      close_out();
   end
endmodule

`default_nettype wire
